// *** vic_aggr_pkg.sv ***
// Shared constants and types for the victim/aggressor pattern control
package vic_aggr_pkg;

   // ------------------------------------------------------------------
   // Field widths
   // ------------------------------------------------------------------
   localparam int DATA_W_DEF = 32;
   localparam int MODE_W     = 3;
   localparam int LAG_W      = 5;
   localparam int SEL_W      = 2;
   localparam int CNT_W      = 32;
   localparam int SPACE_W    = 10;
   localparam int GIDX_W     = 8;

   // ------------------------------------------------------------------
   // Limits and reset values
   // ------------------------------------------------------------------
   localparam logic [LAG_W-1:0]   MAX_LAG     = 5'h18;
   localparam int                 LAG_DEPTH   = 24;
   localparam logic [CNT_W-1:0]   RST_CNT     = 32'h0;
   localparam logic [SPACE_W-1:0] RST_SPACE   = 10'h0;
   localparam logic [LAG_W-1:0]   RST_LAG     = 5'h0;

   // ------------------------------------------------------------------
   // Enumerations
   // ------------------------------------------------------------------
   typedef enum logic [MODE_W-1:0] {
      aggr_none             = 3'h0,
      aggr_const_high       = 3'h1,
      aggr_const_low        = 3'h2,
      aggr_copy             = 3'h3,
      aggr_inverse          = 3'h4,
      aggr_lag_victim       = 3'h5,
      victim_lag_aggr       = 3'h6,
      complex_calib_pattern = 3'h7
   } pattern_mode_e;

   typedef enum logic [SEL_W-1:0] {
      target_external      = 2'h0,
      target_rotate_nibble = 2'h1,
      target_rotate_byte   = 2'h2,
      target_rotate_full   = 2'h3
   } target_policy_e;

   typedef enum logic [3:0] {
      st_idle  = 4'h1,
      st_prime = 4'h2,
      st_issue = 4'h4,
      st_gap   = 4'h8
   } run_state_e;

endpackage // vic_aggr_pkg

// *** lag_line.sv ***
// Per-command history line with a selectable tap
`timescale 1ns/100ps
module lag_line #(
   parameter int W     = 2,
   parameter int DEPTH = 24
) (
   input  wire logic         clk,      // System clock
   input  wire logic         sys_rst,  // Synchronous reset
   input  wire logic         shift_en, // Advance one command step
   input  wire logic [W-1:0] din,      // Current value
   input  wire logic [4:0]   tap_sel,  // Steps of delay, 0 = none
   output logic      [W-1:0] dout      // Delayed value
);
   logic [W-1:0] hist_reg  [DEPTH];
   logic [W-1:0] hist_next [DEPTH];

   always_comb begin
      hist_next = hist_reg;
      if (shift_en) begin
         hist_next[0] = din;
         for (int i = 1; i < DEPTH; i++) begin
            hist_next[i] = hist_reg[i-1];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            hist_reg[i] <= '0;
         end
      end else begin
         hist_reg <= hist_next;
      end
   end

   // Tap 0 is the present value, tap k the value k steps back
   always_comb begin
      if (tap_sel == 5'h0) begin
         dout = din;
      end else begin
         dout = hist_reg[tap_sel-5'h1];
      end
   end
endmodule // lag_line

// *** lane_shaper.sv ***
// One data lane: picks base, victim-derived or held value
`timescale 1ns/100ps
module lane_shaper
   import vic_aggr_pkg::*;
(
   input  wire pattern_mode_e mode,       // Victim mode
   input  wire logic          is_victim,  // This lane is a victim
   input  wire logic          base_bit,   // Data-mode pattern bit
   input  wire logic          grp_victim, // Victim value of this group
   input  wire logic          lag_victim, // Delayed victim value
   input  wire logic          lag_aggr,   // Delayed aggressor value
   input  wire logic          calib_tog,  // Calibration phase
   output logic               lane_out    // Shaped lane value
);
   always_comb begin
      lane_out = base_bit;
      if (is_victim) begin
         if (mode == victim_lag_aggr) begin
            lane_out = lag_aggr;
         end
      end else begin
         case (mode)
            aggr_none:             lane_out = base_bit;
            aggr_const_high:       lane_out = 1'b1;
            aggr_const_low:        lane_out = 1'b0;
            aggr_copy:             lane_out = grp_victim;
            aggr_inverse:          lane_out = ~grp_victim;
            aggr_lag_victim:       lane_out = lag_victim;
            victim_lag_aggr:       lane_out = base_bit;
            complex_calib_pattern: lane_out = grp_victim ^ calib_tog;
            default:               lane_out = base_bit;
         endcase
      end
   end
endmodule // lane_shaper

// *** victim_aggressor_pattern_ctrl.sv ***
// Victim/aggressor pattern, iteration and idle-insertion control
`timescale 1ns/100ps
module victim_aggressor_pattern_ctrl
   import vic_aggr_pkg::*;
#(
   parameter int DW = vic_aggr_pkg::DATA_W_DEF
) (
   input  wire logic                 clk,                     // Clock
   input  wire logic                 sys_rst,                 // Sync reset
   input  wire logic                 run_start,               // Start pulse
   input  wire logic [vic_aggr_pkg::MODE_W-1:0]
                                     aggressor_pattern_sel,   // Victim mode
   input  wire logic [vic_aggr_pkg::LAG_W-1:0]
                                     pattern_lag_cycles,      // Delay
   input  wire logic [vic_aggr_pkg::SEL_W-1:0]
                                     target_bit_policy,       // Victim pick
   input  wire logic [vic_aggr_pkg::CNT_W-1:0]
                                     command_count,           // Commands
   input  wire logic [vic_aggr_pkg::SPACE_W-1:0]
                                     idle_insert_spacing,     // M idles
   input  wire logic [vic_aggr_pkg::SPACE_W-1:0]
                                     burst_cmd_count,         // N per group
   input  wire logic [vic_aggr_pkg::GIDX_W-1:0]
                                     global_target_bit_index, // Victim bit
   input  wire logic [DW-1:0]        pattern_data,            // Data mode
   input  wire logic                 cmd_ready,               // UI ready
   output logic                      cmd_valid,               // UI valid
   output logic      [DW-1:0]        cmd_data,                // UI data
   output logic                      pattern_step,            // Data used
   output logic                      busy,                    // Running
   output logic                      run_done                 // Done pulse
);
   localparam int IW = $clog2(DW);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   run_state_e          state_reg, state_next;
   pattern_mode_e       mode_reg, mode_next;
   target_policy_e      sel_reg, sel_next;
   logic [LAG_W-1:0]    lag_reg, lag_next;
   logic [CNT_W-1:0]    rem_reg, rem_next;
   logic [SPACE_W-1:0]  m_reg, m_next;
   logic [SPACE_W-1:0]  n_reg, n_next;
   logic [SPACE_W-1:0]  burst_reg, burst_next;
   logic [SPACE_W-1:0]  gap_reg, gap_next;
   logic [IW-1:0]       gidx_reg, gidx_next;
   logic [IW-1:0]       rot_reg, rot_next;
   logic                tog_reg, tog_next;
   logic                valid_reg, valid_next;
   logic [DW-1:0]       data_reg, data_next;
   logic                step_reg, step_next;
   logic                busy_reg, busy_next;
   logic                done_reg, done_next;
   logic [DW-1:0]       vmask_reg, vgrp_reg, base_reg;

   logic                accept, last_cmd, gap_go, load;
   logic [IW-1:0]       vpos, gmask;
   logic [DW-1:0]       is_vic, grp_v, shaped;
   logic [1:0]          lag_out;

   assign accept   = valid_reg & cmd_ready;
   assign last_cmd = (rem_reg == 32'h1);
   assign gap_go   = (n_reg != RST_SPACE) && (m_reg != RST_SPACE) &&
                     (burst_reg + 10'h1 == n_reg);
   assign load     = (state_reg == st_prime) ||
                     (state_reg == st_issue && accept && !last_cmd &&
                      !gap_go) ||
                     (state_reg == st_gap && gap_reg == 10'h1);

   // ------------------------------------------------------------------
   // Victim placement
   // ------------------------------------------------------------------
   always_comb begin
      case (sel_reg)
         target_external: begin
            vpos  = gidx_reg;
            gmask = '1;
         end
         target_rotate_nibble: begin
            vpos  = rot_reg;
            gmask = IW'(3);
         end
         target_rotate_byte: begin
            vpos  = rot_reg;
            gmask = IW'(7);
         end
         target_rotate_full: begin
            vpos  = rot_reg;
            gmask = '1;
         end
         default: begin
            vpos  = gidx_reg;
            gmask = '1;
         end
      endcase
   end

   lag_line #(
      .W     (2),
      .DEPTH (LAG_DEPTH)
   ) u_lag (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .shift_en (load),
      .din      ({pattern_data[vpos], pattern_data[vpos ^ IW'(1)]}),
      .tap_sel  (lag_reg),
      .dout     (lag_out)
   );

   for (genvar i = 0; i < DW; i++) begin : g_lane
      // One victim per group; every other lane is an aggressor
      assign is_vic[i] = (((IW'(i) ^ vpos) & gmask) == '0);
      assign grp_v[i]  = pattern_data[(IW'(i) & ~gmask) | (vpos & gmask)];
      lane_shaper u_lane (
         .mode       (mode_reg),
         .is_victim  (is_vic[i]),
         .base_bit   (pattern_data[i]),
         .grp_victim (grp_v[i]),
         .lag_victim (lag_out[1]),
         .lag_aggr   (lag_out[0]),
         .calib_tog  (tog_reg),
         .lane_out   (shaped[i])
      );
   end

   // ------------------------------------------------------------------
   // Run sequencing
   // ------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      mode_next  = mode_reg;
      sel_next   = sel_reg;
      lag_next   = lag_reg;
      rem_next   = rem_reg;
      m_next     = m_reg;
      n_next     = n_reg;
      burst_next = burst_reg;
      gap_next   = gap_reg;
      gidx_next  = gidx_reg;
      rot_next   = rot_reg;
      tog_next   = tog_reg;
      valid_next = valid_reg;
      data_next  = data_reg;
      busy_next  = busy_reg;
      step_next  = 1'b0;
      done_next  = 1'b0;
      case (state_reg)
         st_idle: begin
            // A zero count is illegal; it is ignored rather than run
            if (run_start && command_count != RST_CNT) begin
               mode_next  = pattern_mode_e'(aggressor_pattern_sel);
               sel_next   = target_policy_e'(target_bit_policy);
               // Values above the limit would read past the end of the 24-entry history
               lag_next   = (pattern_lag_cycles > MAX_LAG) ?
                            MAX_LAG : pattern_lag_cycles;
               rem_next   = command_count;
               m_next     = idle_insert_spacing;
               n_next     = burst_cmd_count;
               gidx_next  = global_target_bit_index[IW-1:0];
               burst_next = RST_SPACE;
               rot_next   = '1;
               tog_next   = 1'b0;
               busy_next  = 1'b1;
               state_next = st_prime;
            end
         end
         st_prime: begin
            valid_next = 1'b1;
            state_next = st_issue;
         end
         st_issue: begin
            if (accept) begin
               rem_next = rem_reg - 32'h1;
               if (last_cmd) begin
                  valid_next = 1'b0;
                  done_next  = 1'b1;
                  busy_next  = 1'b0;
                  state_next = st_idle;
               end else if (gap_go) begin
                  valid_next = 1'b0;
                  gap_next   = m_reg;
                  burst_next = RST_SPACE;
                  state_next = st_gap;
               end else begin
                  burst_next = burst_reg + 10'h1;
               end
            end
         end
         st_gap: begin
            gap_next = gap_reg - 10'h1;
            if (gap_reg == 10'h1) begin
               valid_next = 1'b1;
               state_next = st_issue;
            end
         end
         default: begin
            state_next = st_idle;
            valid_next = 1'b0;
            busy_next  = 1'b0;
         end
      endcase
      if (load) begin
         data_next = shaped;
         step_next = 1'b1;
         rot_next  = rot_reg - IW'(1);
         tog_next  = ~tog_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= st_idle;
         mode_reg  <= aggr_none;
         sel_reg   <= target_external;
         lag_reg   <= RST_LAG;
         rem_reg   <= RST_CNT;
         m_reg     <= RST_SPACE;
         n_reg     <= RST_SPACE;
         burst_reg <= RST_SPACE;
         gap_reg   <= RST_SPACE;
         gidx_reg  <= '0;
         rot_reg   <= '1;
         tog_reg   <= 1'b0;
         valid_reg <= 1'b0;
         data_reg  <= '0;
         step_reg  <= 1'b0;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         mode_reg  <= mode_next;
         sel_reg   <= sel_next;
         lag_reg   <= lag_next;
         rem_reg   <= rem_next;
         m_reg     <= m_next;
         n_reg     <= n_next;
         burst_reg <= burst_next;
         gap_reg   <= gap_next;
         gidx_reg  <= gidx_next;
         rot_reg   <= rot_next;
         tog_reg   <= tog_next;
         valid_reg <= valid_next;
         data_reg  <= data_next;
         step_reg  <= step_next;
         busy_reg  <= busy_next;
         done_reg  <= done_next;
      end
   end

   assign cmd_valid    = valid_reg;
   assign cmd_data     = data_reg;
   assign pattern_step = step_reg;
   assign busy         = busy_reg;
   assign run_done     = done_reg;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   logic [CNT_W-1:0]   issued_reg;
   logic [SPACE_W-1:0] gap_run_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         vmask_reg   <= '0;
         vgrp_reg    <= '0;
         base_reg    <= '0;
         issued_reg  <= RST_CNT;
         gap_run_reg <= RST_SPACE;
      end else begin
         if (load) begin
            vmask_reg <= is_vic;
            vgrp_reg  <= grp_v;
            base_reg  <= pattern_data;
         end
         if (state_reg == st_idle) begin
            issued_reg <= RST_CNT;
         end else if (accept) begin
            issued_reg <= issued_reg + 32'h1;
         end
         gap_run_reg <= (state_reg == st_gap) ?
                        gap_run_reg + 10'h1 : RST_SPACE;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   const_high_a: assert property (cmd_valid && mode_reg == aggr_const_high
      |-> (cmd_data | vmask_reg) == '1)
      else $error("aggressors not held high");
   const_low_a: assert property (cmd_valid && mode_reg == aggr_const_low
      |-> (cmd_data & ~vmask_reg) == '0)
      else $error("aggressors not held low");
   aggr_copy_a: assert property (cmd_valid && mode_reg == aggr_copy
      |-> cmd_data == vgrp_reg)
      else $error("aggressors differ from victim");
   aggr_inverse_a: assert property (cmd_valid && mode_reg == aggr_inverse
      |-> (cmd_data ^ vgrp_reg) == ~vmask_reg)
      else $error("aggressors not inverse of victim");
   plain_data_a: assert property (cmd_valid && mode_reg == aggr_none
      |-> cmd_data == base_reg)
      else $error("data altered with no victim mode");
   ext_victim_a: assert property (cmd_valid && sel_reg == target_external
      |-> vmask_reg == (DW'(1) << gidx_reg))
      else $error("victim not at global index");
   rotate_span_a: assert property (cmd_valid
      && sel_reg == target_rotate_nibble
      |-> $countones(vmask_reg) == DW / 4)
      else $error("nibble rotation victim count wrong");
   cmd_total_a: assert property ($rose(run_done)
      |-> issued_reg == $past(rem_reg) + $past(issued_reg))
      else $error("command total differs from count");
   idle_len_a: assert property (state_reg == st_gap && gap_reg == 10'h1
      |-> gap_run_reg + 10'h1 == m_reg ##1 cmd_valid)
      else $error("idle insertion length wrong");
   group_len_a: assert property (state_reg == st_issue && accept && gap_go
      && !last_cmd |=> state_reg == st_gap && !cmd_valid)
      else $error("group not ended after N commands");
   lag_limit_a: assert property (lag_reg <= MAX_LAG)
      else $error("delay above limit");

   gap_seen_c: cover property (state_reg == st_gap ##1 cmd_valid);
   run_end_c: cover property (run_done);
   rot_full_c: cover property (cmd_valid
      && sel_reg == target_rotate_full);
   lag_mode_c: cover property (cmd_valid && mode_reg == victim_lag_aggr
      && lag_reg == MAX_LAG);
endmodule // victim_aggressor_pattern_ctrl

// *** ui_sink_model.sv ***
// User interface model that takes shaped commands, promptly or slowly
`timescale 1ns/100ps
module ui_sink_model (
   input  wire logic clk,       // System clock
   input  wire logic sys_rst,   // Synchronous reset
   input  wire logic slow,      // Refuse every other offered cycle
   input  wire logic cmd_valid, // Command offered
   output logic      cmd_ready  // Command taken at this edge
);
   // ------------------------------------------------------------------
   // Ready pattern
   // ------------------------------------------------------------------
   logic phase_reg;

   // Phase moves only while a command waits, so a slow sink really stalls
   always @(negedge clk) begin
      if (sys_rst) begin
         phase_reg <= 1'b0;
      end else if (cmd_valid) begin
         phase_reg <= ~phase_reg;
      end
   end

   assign cmd_ready = ~slow | phase_reg;
endmodule // ui_sink_model

// *** testbench.sv ***
// Self-checking bench for the victim/aggressor pattern control
`timescale 1ns/100ps
module testbench;
   import vic_aggr_pkg::*;
   localparam int DW = 32;
   logic          clk, sys_rst, run_start, slow;
   logic          cmd_ready, cmd_valid, pattern_step, busy, run_done;
   logic [2:0]    mode;
   logic [4:0]    lag;
   logic [1:0]    pol;
   logic [31:0]   cnt;
   logic [9:0]    m_idle, n_burst;
   logic [7:0]    gidx;
   logic [DW-1:0] pdata, cmd_data;
   int            num_errors, checks, cyc, k_load, done_t;
   logic [DW-1:0] seen_q[$];
   int            time_q[$];

   victim_aggressor_pattern_ctrl #(.DW(DW))
      victim_aggressor_pattern_ctrl_inst (
      .clk(clk), .sys_rst(sys_rst), .run_start(run_start),
      .aggressor_pattern_sel(mode), .pattern_lag_cycles(lag),
      .target_bit_policy(pol), .command_count(cnt),
      .idle_insert_spacing(m_idle), .burst_cmd_count(n_burst),
      .global_target_bit_index(gidx), .pattern_data(pdata),
      .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
      .pattern_step(pattern_step), .busy(busy), .run_done(run_done));

   ui_sink_model ui_sink_model_inst (
      .clk(clk), .sys_rst(sys_rst), .slow(slow),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready));

   // ------------------------------------------------------------------
   // Clock, timeout and monitor
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (!sys_rst && cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
         seen_q.push_back(cmd_data);
         time_q.push_back(cyc);
      end
      if (run_done === 1'b1) begin
         done_t = cyc;
      end
      if (cyc == 6000) begin
         num_errors++;
         test_done();
      end
   end

   // Next data word is offered once the previous one has been taken
   always @(negedge clk) begin
      if (pattern_step === 1'b1) begin
         k_load++;
         pdata <= gen(k_load);
      end
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [DW-1:0] gen(int k);
      return 32'h5a3c96e1 ^ (32'(k) * 32'h9e3779b9);
   endfunction

   function automatic logic [DW-1:0] exp_w(int k);
      logic [DW-1:0] p, h, vm, r;
      logic [4:0]    vi;
      int            l;
      p  = gen(k);
      vi = gidx[4:0];
      l  = (lag > 5'h18) ? 24 : int'(lag);
      h  = (k >= l) ? gen(k - l) : '0;
      for (int b = 0; b < DW; b++) begin
         case (pol)
            2'h0: vm[b] = (b == int'(vi));
            2'h1: vm[b] = (b % 4 == 3 - k % 4);
            2'h2: vm[b] = (b % 8 == 7 - k % 8);
            default: vm[b] = (b == DW - 1 - k % DW);
         endcase
      end
      case (mode)
         3'h1: r = p | ~vm;
         3'h2: r = p & vm;
         3'h3: r = (p & vm) | ({DW{p[vi]}} & ~vm);
         3'h4: r = (p & vm) | ({DW{~p[vi]}} & ~vm);
         3'h5: r = (p & vm) | ({DW{h[vi]}} & ~vm);
         3'h6: r = (p & ~vm) | ({DW{h[vi ^ 5'h1]}} & vm);
         3'h7: r = (p & vm) | ({DW{p[vi] ^ (k % 2 == 1)}} & ~vm);
         default: r = p;
      endcase
      return r;
   endfunction

   task automatic check(string nm, logic [DW-1:0] seen, logic [DW-1:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done();
      if (num_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One run from a fresh reset; the delay history is cleared only there
   task automatic run(logic [2:0] md, logic [4:0] lg, logic [1:0] pl,
                      int c, int mi, int ni, logic sl);
      int t;
      int gap;
      @(negedge clk);
      sys_rst = 1'b1;
      mode    = md;
      lag     = lg;
      pol     = pl;
      cnt     = 32'(c);
      m_idle  = 10'(mi);
      n_burst = 10'(ni);
      slow    = sl;
      k_load  = 0;
      pdata   = gen(0);
      seen_q.delete();
      time_q.delete();
      done_t  = -1;
      repeat (10) @(negedge clk);
      sys_rst   = 1'b0;
      run_start = 1'b1;
      @(negedge clk);
      run_start = 1'b0;
      check("busy", busy, (c != 0) ? 32'h1 : 32'h0);
      t = 0;
      while (done_t < 0 && t < ((c != 0) ? 1000 : 20)) begin
         @(negedge clk);
         t++;
      end
      check("accepts", 32'(seen_q.size()), 32'(c));
      check("busy_end", busy, 32'h0);
      check("steps", 32'(k_load), 32'(c));
      for (int k = 0; k < seen_q.size(); k++) begin
         check("cmd_data", seen_q[k], exp_w(k));
      end
      for (int k = 1; k < time_q.size() && !sl; k++) begin
         gap = (mi != 0 && ni != 0 && k % ni == 0) ? mi + 1 : 1;
         check("spacing", 32'(time_q[k] - time_q[k-1]), 32'(gap));
      end
      if (c != 0) begin
         check("run_done", 32'(done_t), 32'(time_q[c-1] + 1));
      end
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      run_start = 1'b0;
      slow = 1'b0;
      mode = 3'h0;
      lag = 5'h0;
      pol = 2'h0;
      cnt = 32'h0;
      m_idle = 10'h0;
      n_burst = 10'h0;
      gidx = 8'h25;
      pdata = '0;
      num_errors = 0;
      checks = 0;
      cyc = 0;
      // Mode 7 runs with the bench pattern standing in for calibration data
      for (int md = 0; md < 8; md++) begin
         run(3'(md), 5'h3, 2'h0, 6, 0, 0, md[0]);
      end
      for (int pl = 1; pl < 4; pl++) begin
         run(3'h2, 5'h0, 2'(pl), 40, 0, 0, 1'b0);
         run(3'h1, 5'h0, 2'(pl), 9, 0, 0, 1'b1);
      end
      gidx = 8'h1e;
      run(3'h3, 5'h0, 2'h0, 4, 0, 0, 1'b0);
      run(3'h1, 5'h0, 2'h0, 11, 3, 4, 1'b0);
      run(3'h0, 5'h0, 2'h0, 5, 1, 1, 1'b0);
      run(3'h5, 5'h18, 2'h0, 30, 0, 0, 1'b0);
      run(3'h6, 5'h1f, 2'h0, 28, 0, 0, 1'b1);
      run(3'h5, 5'h0, 2'h0, 3, 0, 0, 1'b0);
      run(3'h1, 5'h0, 2'h0, 0, 0, 0, 1'b0);
      test_done();
   end
endmodule // testbench
